// ==== design/mscr_regs.sv ====
`timescale 1ns/10ps
module mscr_regs (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        WR_EN_IN,
  input  wire logic        RD_EN_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        FRAME_PUSH_IN,
  input  wire logic        FRAME_POP_IN,
  input  wire logic        OVERRUN_IN,
  input  wire logic [6:0]  MOTION_EVT_IN,
  input  wire logic [6:0]  DATA_EVT_IN,
  output logic      [7:0]  RDATA_OUT,
  output logic      [1:0]  RANGE_SEL_OUT,
  output logic      [2:0]  BAND_SEL_OUT,
  output logic             RATE_DOUBLE_OUT,
  output logic             ACTIVE_MODE_OUT,
  output logic      [1:0]  PRESET_CODE_OUT,
  output logic      [16:0] PRESET_CYCLES_OUT,
  output logic      [3:0]  SLEEP_CODE_OUT,
  output logic             POWER_CYCLE_OUT,
  output logic             PED_RUN_OUT,
  output logic      [6:0]  PED_SAMPLES_OUT,
  output logic      [6:0]  PED_PRECISION_OUT,
  output logic             PED_CLEAR_OUT,
  output logic      [7:0]  PED_MIN_WIN_OUT,
  output logic      [10:0] PED_QUIT_WIN_OUT,
  output logic             PED_RAW_OUT,
  output logic             SAMPLE_RAW_OUT,
  output logic             KNOCK_RAW_OUT,
  output logic             IRQ_PIN_A_OUT,
  output logic             IRQ_PIN_B_OUT
);
  // register image
  logic [7:0]  r_range;
  logic [7:0]  r_band;
  logic [7:0]  r_power;
  logic [7:0]  r_ped0;
  logic [7:0]  r_ped1;
  logic [7:0]  r_ped2;
  logic [7:0]  r_ped3;
  logic [7:0]  r_en_mot;
  logic [7:0]  r_en_data;
  logic [7:0]  r_src;
  logic [7:0]  r_mapa_mot;
  logic [7:0]  r_mapa_data;
  logic [7:0]  r_mapb_mot;
  logic [7:0]  r_mapb_data;
  logic [6:0]  level;
  logic        overrun;
  logic [7:0]  next_range;
  logic [7:0]  next_band;
  logic [7:0]  next_power;
  logic [7:0]  next_ped0;
  logic [7:0]  next_ped1;
  logic [7:0]  next_ped2;
  logic [7:0]  next_ped3;
  logic [7:0]  next_en_mot;
  logic [7:0]  next_en_data;
  logic [7:0]  next_src;
  logic [7:0]  next_mapa_mot;
  logic [7:0]  next_mapa_data;
  logic [7:0]  next_mapb_mot;
  logic [7:0]  next_mapb_data;
  logic [6:0]  next_level;
  logic        next_overrun;
  logic [7:0]  next_rdata;
  logic        next_ped_clear;
  // derived outputs
  logic [1:0]  next_range_sel;
  // seventeen bits so the longest preset does not wrap
  logic [16:0] next_preset_cyc;
  logic        next_pin_a;
  logic        next_pin_b;
  logic        high_any;
  logic [6:0]  live_mot;
  logic [6:0]  live_data;

  always_comb begin
    next_range     = r_range;
    next_band      = r_band;
    next_power     = r_power;
    next_ped0      = r_ped0;
    next_ped1      = r_ped1;
    next_ped2      = r_ped2;
    next_ped3      = r_ped3;
    next_en_mot    = r_en_mot;
    next_en_data   = r_en_data;
    next_src       = r_src;
    next_mapa_mot  = r_mapa_mot;
    next_mapa_data = r_mapa_data;
    next_mapb_mot  = r_mapb_mot;
    next_mapb_data = r_mapb_data;
    // clear is a strobe only, never stored, so it reads back 0
    next_ped_clear = 1'b0;
    if (WR_EN_IN) begin
      unique case (ADDR_IN)
        mscr_pkg::ADDR_RANGE:     next_range     = WDATA_IN & mscr_pkg::MASK_RANGE;
        mscr_pkg::ADDR_BAND:      next_band      = WDATA_IN & mscr_pkg::MASK_BAND;
        mscr_pkg::ADDR_POWER:     next_power     = WDATA_IN;
        mscr_pkg::ADDR_PED0:      next_ped0      = WDATA_IN & mscr_pkg::MASK_PED0;
        mscr_pkg::ADDR_PED1: begin
          next_ped1      = {1'b0, WDATA_IN[6:0]};
          next_ped_clear = WDATA_IN[mscr_pkg::POS_PED_CLEAR];
        end
        mscr_pkg::ADDR_PED2:      next_ped2      = WDATA_IN;
        mscr_pkg::ADDR_PED3:      next_ped3      = WDATA_IN;
        mscr_pkg::ADDR_EN_MOTION: next_en_mot    = WDATA_IN & mscr_pkg::MASK_EN_MOTION;
        mscr_pkg::ADDR_EN_DATA:   next_en_data   = WDATA_IN & mscr_pkg::MASK_DATA_GRP;
        mscr_pkg::ADDR_SRC:       next_src       = WDATA_IN & mscr_pkg::MASK_SRC;
        mscr_pkg::ADDR_MAPA_MOT:  next_mapa_mot  = WDATA_IN & mscr_pkg::MASK_MAP_MOT;
        mscr_pkg::ADDR_MAPA_DATA: next_mapa_data = WDATA_IN & mscr_pkg::MASK_MAPA_DATA;
        mscr_pkg::ADDR_MAPB_MOT:  next_mapb_mot  = WDATA_IN & mscr_pkg::MASK_MAP_MOT;
        mscr_pkg::ADDR_MAPB_DATA: next_mapb_data = WDATA_IN & mscr_pkg::MASK_MAPB_DATA;
        default: ;
      endcase
    end
  end

  // frame counter; config write clears it, a push in that cycle is dropped
  always_comb begin
    next_level   = level;
    next_overrun = overrun | OVERRUN_IN;
    if (WR_EN_IN && (ADDR_IN == mscr_pkg::ADDR_WMK || ADDR_IN == mscr_pkg::ADDR_BUF_CFG1)) begin
      next_level = mscr_pkg::LEVEL_EMPTY;
    end else if (FRAME_PUSH_IN && !FRAME_POP_IN && level != 7'h7f) begin
      next_level = level + 7'h01;
    end else if (FRAME_POP_IN && !FRAME_PUSH_IN && level != mscr_pkg::LEVEL_EMPTY) begin
      next_level = level - 7'h01;
    end
    // reading the status word clears the sticky flag unless overrun fires now
    if (RD_EN_IN && ADDR_IN == mscr_pkg::ADDR_LEVEL && !OVERRUN_IN) begin
      next_overrun = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (RD_EN_IN) begin
      unique case (ADDR_IN)
        mscr_pkg::ADDR_LEVEL:     next_rdata = {overrun, level};
        mscr_pkg::ADDR_RANGE:     next_rdata = r_range;
        mscr_pkg::ADDR_BAND:      next_rdata = r_band;
        mscr_pkg::ADDR_POWER:     next_rdata = r_power;
        mscr_pkg::ADDR_PED0:      next_rdata = r_ped0;
        mscr_pkg::ADDR_PED1:      next_rdata = r_ped1;
        mscr_pkg::ADDR_PED2:      next_rdata = r_ped2;
        mscr_pkg::ADDR_PED3:      next_rdata = r_ped3;
        mscr_pkg::ADDR_EN_MOTION: next_rdata = r_en_mot;
        mscr_pkg::ADDR_EN_DATA:   next_rdata = r_en_data;
        mscr_pkg::ADDR_SRC:       next_rdata = r_src;
        mscr_pkg::ADDR_MAPA_MOT:  next_rdata = r_mapa_mot;
        mscr_pkg::ADDR_MAPA_DATA: next_rdata = r_mapa_data;
        mscr_pkg::ADDR_MAPB_MOT:  next_rdata = r_mapb_mot;
        mscr_pkg::ADDR_MAPB_DATA: next_rdata = r_mapb_data;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  // decode from the next image so outputs track writes with one cycle latency
  always_comb begin
    unique case (next_range[3:0])
      mscr_pkg::RANGE_CODE_4G: next_range_sel = mscr_pkg::MSCR_G4;
      mscr_pkg::RANGE_CODE_8G: next_range_sel = mscr_pkg::MSCR_G8;
      default:                 next_range_sel = mscr_pkg::MSCR_G2;
    endcase
    unique case (next_power[5:4])
      2'b11:   next_preset_cyc = 17'(mscr_pkg::PRESET_CYC_3);
      2'b10:   next_preset_cyc = 17'(mscr_pkg::PRESET_CYC_2);
      2'b01:   next_preset_cyc = 17'(mscr_pkg::PRESET_CYC_1);
      default: next_preset_cyc = 17'(mscr_pkg::PRESET_CYC_0);
    endcase
  end

  // pins use live register values; events are level inputs
  always_comb begin
    high_any    = |(r_en_data[2:0] & DATA_EVT_IN[2:0]);
    live_mot    = MOTION_EVT_IN & r_en_mot[7:1];
    live_data   = DATA_EVT_IN & {r_en_data[6:3], 3'b000};
    next_pin_a  = |(live_mot & r_mapa_mot[7:1])
                | |({live_data[6:3], high_any} & r_mapa_data[6:2]);
    next_pin_b  = |(live_mot & r_mapb_mot[7:1])
                | |({live_data[6:3], high_any} & r_mapb_data[6:2]);
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      r_range           <= mscr_pkg::RST_DEFAULT;
      r_band            <= mscr_pkg::RST_DEFAULT;
      r_power           <= mscr_pkg::RST_DEFAULT;
      r_ped0            <= mscr_pkg::RST_PED0;
      r_ped1            <= mscr_pkg::RST_DEFAULT;
      r_ped2            <= mscr_pkg::RST_DEFAULT;
      r_ped3            <= mscr_pkg::RST_DEFAULT;
      r_en_mot          <= mscr_pkg::RST_DEFAULT;
      r_en_data         <= mscr_pkg::RST_DEFAULT;
      r_src             <= mscr_pkg::RST_DEFAULT;
      r_mapa_mot        <= mscr_pkg::RST_DEFAULT;
      r_mapa_data       <= mscr_pkg::RST_DEFAULT;
      r_mapb_mot        <= mscr_pkg::RST_DEFAULT;
      r_mapb_data       <= mscr_pkg::RST_DEFAULT;
      level             <= mscr_pkg::LEVEL_EMPTY;
      overrun           <= 1'b0;
      RDATA_OUT         <= 8'h00;
      RANGE_SEL_OUT     <= mscr_pkg::MSCR_G2;
      BAND_SEL_OUT      <= 3'h0;
      RATE_DOUBLE_OUT   <= 1'b0;
      ACTIVE_MODE_OUT   <= mscr_pkg::MSCR_STANDBY;
      PRESET_CODE_OUT   <= 2'h0;
      PRESET_CYCLES_OUT <= 17'(mscr_pkg::PRESET_CYC_0);
      SLEEP_CODE_OUT    <= 4'h0;
      POWER_CYCLE_OUT   <= 1'b0;
      PED_RUN_OUT       <= 1'b0;
      PED_SAMPLES_OUT   <= {mscr_pkg::RST_PED0[4:0], 2'b00};
      PED_PRECISION_OUT <= 7'h00;
      PED_CLEAR_OUT     <= 1'b0;
      PED_MIN_WIN_OUT   <= 8'h00;
      PED_QUIT_WIN_OUT  <= 11'h000;
      PED_RAW_OUT       <= 1'b0;
      SAMPLE_RAW_OUT    <= 1'b0;
      KNOCK_RAW_OUT     <= 1'b0;
      IRQ_PIN_A_OUT     <= 1'b0;
      IRQ_PIN_B_OUT     <= 1'b0;
    end else begin
      r_range           <= next_range;
      r_band            <= next_band;
      r_power           <= next_power;
      r_ped0            <= next_ped0;
      r_ped1            <= next_ped1;
      r_ped2            <= next_ped2;
      r_ped3            <= next_ped3;
      r_en_mot          <= next_en_mot;
      r_en_data         <= next_en_data;
      r_src             <= next_src;
      r_mapa_mot        <= next_mapa_mot;
      r_mapa_data       <= next_mapa_data;
      r_mapb_mot        <= next_mapb_mot;
      r_mapb_data       <= next_mapb_data;
      level             <= next_level;
      overrun           <= next_overrun;
      RDATA_OUT         <= next_rdata;
      RANGE_SEL_OUT     <= next_range_sel;
      BAND_SEL_OUT      <= next_band[2:0];
      RATE_DOUBLE_OUT   <= next_band[mscr_pkg::POS_RATE_DOUBLE];
      ACTIVE_MODE_OUT   <= next_power[mscr_pkg::POS_ACTIVE];
      PRESET_CODE_OUT   <= next_power[5:4];
      PRESET_CYCLES_OUT <= next_preset_cyc;
      SLEEP_CODE_OUT    <= next_power[3:0];
      POWER_CYCLE_OUT   <= (next_power[3:0] != 4'h0);
      PED_RUN_OUT       <= next_ped0[mscr_pkg::POS_PED_RUN];
      PED_SAMPLES_OUT   <= {next_ped0[4:0], 2'b00};
      PED_PRECISION_OUT <= next_ped1[6:0];
      PED_CLEAR_OUT     <= next_ped_clear;
      PED_MIN_WIN_OUT   <= next_ped2;
      PED_QUIT_WIN_OUT  <= {next_ped3, 3'b000};
      PED_RAW_OUT       <= next_src[mscr_pkg::POS_SRC_PED];
      SAMPLE_RAW_OUT    <= next_src[mscr_pkg::POS_SRC_SAMPLE];
      KNOCK_RAW_OUT     <= next_src[mscr_pkg::POS_SRC_KNOCK];
      IRQ_PIN_A_OUT     <= next_pin_a;
      IRQ_PIN_B_OUT     <= next_pin_b;
    end
  end
endmodule

// ==== design/mscr_pkg.sv ====
// Contract
// - buffer frame count is 7 bits, zero when empty, cleared on drain or config write.
// - overrun flag sets to 1 on buffer overrun, stays 0 otherwise.
// - range code 0001 gives 2g, 0010 gives 4g, 0100 gives 8g, others 2g.
// - rate-double bit 1 gives output rate 4x bandwidth, 0 gives 2x.
// - low three bandwidth bits pick 3.9Hz to 500Hz doubling; upper two ignored.
// - active-enable bit 1 enters active mode, 0 stays or returns to standby.
// - settle code picks preset 2048us, 768us, 96us or 12us for codes 11 to 00.
// - sleep code 0000 disables power cycling; 0001-0101 0.5ms; up to 1s at 1111.
// - dynamic threshold window is four times the 5-bit sample count; reset 48.
// - writing 1 to pedometer clear resets the 16-bit step total.
// - new-sample update only when change exceeds precision field times 3.9mg.
// - minimum step window is short-window field times one output period.
// - step counting quits after quit-window field times 8 output periods.
// - motion irq enables in bits 7..1, all clear at reset.
// - watermark, full, data ready, low-g enables plus high-g z,y,x in bits 2..0.
// - three source bits choose unfiltered when 1, filtered when 0.
// - each source has a pin a map bit; 1 drives the pin, 0 keeps it off.
// - orientation, tap and step sources have pin b map bits.
// - watermark, full, data ready, low-g, high-g sources have pin b map bits.
package mscr_pkg;
  localparam logic [7:0] ADDR_LEVEL      = 8'h0e;
  localparam logic [7:0] ADDR_RANGE      = 8'h0f;
  localparam logic [7:0] ADDR_BAND       = 8'h10;
  localparam logic [7:0] ADDR_POWER      = 8'h11;
  localparam logic [7:0] ADDR_PED0       = 8'h12;
  localparam logic [7:0] ADDR_PED1       = 8'h13;
  localparam logic [7:0] ADDR_PED2       = 8'h14;
  localparam logic [7:0] ADDR_PED3       = 8'h15;
  localparam logic [7:0] ADDR_EN_MOTION  = 8'h16;
  localparam logic [7:0] ADDR_EN_DATA    = 8'h17;
  localparam logic [7:0] ADDR_SRC        = 8'h18;
  localparam logic [7:0] ADDR_MAPA_MOT   = 8'h19;
  localparam logic [7:0] ADDR_MAPA_DATA  = 8'h1a;
  localparam logic [7:0] ADDR_MAPB_MOT   = 8'h1b;
  localparam logic [7:0] ADDR_MAPB_DATA  = 8'h1c;
  localparam logic [7:0] ADDR_WMK        = 8'h31;
  localparam logic [7:0] ADDR_BUF_CFG1   = 8'h3e;
  localparam logic [7:0] RST_DEFAULT     = 8'h00;
  localparam logic [7:0] RST_PED0        = 8'h0c;
  localparam logic [7:0] MASK_RANGE      = 8'h0f;
  localparam logic [7:0] MASK_BAND       = 8'h3f;
  localparam logic [7:0] MASK_PED0       = 8'h9f;
  localparam logic [7:0] MASK_EN_MOTION  = 8'hfe;
  localparam logic [7:0] MASK_DATA_GRP   = 8'h7f;
  localparam logic [7:0] MASK_SRC        = 8'h70;
  localparam logic [7:0] MASK_MAP_MOT    = 8'hfe;
  localparam logic [7:0] MASK_MAPA_DATA  = 8'h7c;
  localparam logic [7:0] MASK_MAPB_DATA  = 8'h7c;
  localparam int         POS_RATE_DOUBLE = 5;
  localparam int         POS_ACTIVE      = 7;
  localparam int         POS_MUST_ONE    = 6;
  localparam int         POS_PED_RUN     = 7;
  localparam int         POS_PED_CLEAR   = 7;
  localparam int         POS_SRC_PED     = 6;
  localparam int         POS_SRC_SAMPLE  = 5;
  localparam int         POS_SRC_KNOCK   = 4;
  localparam logic [3:0] RANGE_CODE_4G   = 4'h2;
  localparam logic [3:0] RANGE_CODE_8G   = 4'h4;
  localparam logic [6:0] LEVEL_EMPTY     = 7'h00;
  localparam int         CLK_HZ          = 40000000;
  localparam int         PRESET_US_0     = 12;
  localparam int         PRESET_US_1     = 96;
  localparam int         PRESET_US_2     = 768;
  localparam int         PRESET_US_3     = 2048;
  localparam int         PRESET_CYC_0    = (PRESET_US_0 * (CLK_HZ / 1000000));
  localparam int         PRESET_CYC_1    = (PRESET_US_1 * (CLK_HZ / 1000000));
  localparam int         PRESET_CYC_2    = (PRESET_US_2 * (CLK_HZ / 1000000));
  localparam int         PRESET_CYC_3    = (PRESET_US_3 * (CLK_HZ / 1000000));
  typedef enum logic [1:0] {
    MSCR_G2 = 2'b00,
    MSCR_G4 = 2'b01,
    MSCR_G8 = 2'b10
  } mscr_range_e;
  typedef enum logic [0:0] {
    MSCR_STANDBY = 1'b0,
    MSCR_ACTIVE  = 1'b1
  } mscr_mode_e;
endpackage

// ==== dv/mscr_regs_properties.sv ====
`timescale 1ns/10ps
module mscr_regs_checker (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        WR_EN_IN,
  input wire logic        RD_EN_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        FRAME_PUSH_IN,
  input wire logic        OVERRUN_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic [1:0]  RANGE_SEL_OUT,
  input wire logic [2:0]  BAND_SEL_OUT,
  input wire logic        RATE_DOUBLE_OUT,
  input wire logic        ACTIVE_MODE_OUT,
  input wire logic [1:0]  PRESET_CODE_OUT,
  input wire logic [16:0] PRESET_CYCLES_OUT,
  input wire logic [6:0]  PED_SAMPLES_OUT,
  input wire logic        PED_CLEAR_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  function automatic logic [1:0] range_of(input logic [3:0] c);
    return (c == 4'h2) ? 2'b01 : (c == 4'h4) ? 2'b10 : 2'b00;
  endfunction
  // cycles of the 40 MHz clock for 12, 96, 768 and 2048 us
  function automatic logic [16:0] cyc_of(input logic [1:0] c);
    return (c == 2'b00) ? 17'h001e0 : (c == 2'b01) ? 17'h00f00
         : (c == 2'b10) ? 17'h07800 : 17'h14000;
  endfunction
  sequence s_wr(logic [7:0] a);
    WR_EN_IN && ADDR_IN == a;
  endsequence
  sequence s_clear_then_read;
    (WR_EN_IN && (ADDR_IN == 8'h31 || ADDR_IN == 8'h3e)) ##1 !FRAME_PUSH_IN
      ##1 (RD_EN_IN && ADDR_IN == 8'h0e);
  endsequence
  sequence s_clear_pulse;
    PED_CLEAR_OUT ##1 !PED_CLEAR_OUT;
  endsequence
  property p_level_clear;
    s_clear_then_read |=> RDATA_OUT[6:0] == 7'h00;
  endproperty
  property p_overrun;
    OVERRUN_IN ##1 !RD_EN_IN ##1 (RD_EN_IN && ADDR_IN == 8'h0e) |=> RDATA_OUT[7];
  endproperty
  property p_range;
    s_wr(8'h0f) |=> RANGE_SEL_OUT == range_of($past(WDATA_IN[3:0]));
  endproperty
  property p_rate;
    s_wr(8'h10) |=> RATE_DOUBLE_OUT == $past(WDATA_IN[5]);
  endproperty
  property p_band;
    s_wr(8'h10) |=> BAND_SEL_OUT == $past(WDATA_IN[2:0]);
  endproperty
  property p_active;
    s_wr(8'h11) |=> ACTIVE_MODE_OUT == $past(WDATA_IN[7]);
  endproperty
  property p_preset;
    s_wr(8'h11) |=> PRESET_CODE_OUT == $past(WDATA_IN[5:4])
      && PRESET_CYCLES_OUT == cyc_of($past(WDATA_IN[5:4]));
  endproperty
  property p_samples;
    s_wr(8'h12) |=> PED_SAMPLES_OUT == {$past(WDATA_IN[4:0]), 2'b00};
  endproperty
  property p_clear;
    s_wr(8'h13) ##0 WDATA_IN[7] |=> s_clear_pulse;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("level not cleared");
  a_overrun: assert property (p_overrun) else $error("overrun flag missing");
  a_range: assert property (p_range) else $error("range select wrong");
  a_rate: assert property (p_rate) else $error("rate double wrong");
  a_band: assert property (p_band) else $error("band select wrong");
  a_active: assert property (p_active) else $error("active mode wrong");
  a_preset: assert property (p_preset) else $error("preset wrong");
  a_samples: assert property (p_samples) else $error("sample count wrong");
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
endmodule
bind mscr_regs mscr_regs_checker i_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .OVERRUN_IN(OVERRUN_IN), .RDATA_OUT(RDATA_OUT),
  .RANGE_SEL_OUT(RANGE_SEL_OUT), .BAND_SEL_OUT(BAND_SEL_OUT), .RATE_DOUBLE_OUT(RATE_DOUBLE_OUT),
  .ACTIVE_MODE_OUT(ACTIVE_MODE_OUT), .PRESET_CODE_OUT(PRESET_CODE_OUT),
  .PRESET_CYCLES_OUT(PRESET_CYCLES_OUT), .PED_SAMPLES_OUT(PED_SAMPLES_OUT),
  .PED_CLEAR_OUT(PED_CLEAR_OUT), .FRAME_PUSH_IN(FRAME_PUSH_IN));

// ==== dv/mscr_host.sv ====
`timescale 1ns/10ps
module mscr_host (
  input  wire logic       CLK_IN,
  input  wire logic [7:0] RDATA_IN,
  output logic            WR_EN_OUT,
  output logic            RD_EN_OUT,
  output logic      [7:0] ADDR_OUT,
  output logic      [7:0] WDATA_OUT
);
  initial {WR_EN_OUT, RD_EN_OUT, ADDR_OUT, WDATA_OUT} = '0;
  // released bus shows inverted junk so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_IN);
    ADDR_OUT = a;
    WDATA_OUT = (a == mscr_pkg::ADDR_POWER) ? (d | 8'h40) : d;
    WR_EN_OUT = 1'b1;
    @(negedge CLK_IN);
    WR_EN_OUT = 1'b0;
    {ADDR_OUT, WDATA_OUT} = ~{ADDR_OUT, WDATA_OUT};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK_IN);
    ADDR_OUT = a;
    RD_EN_OUT = 1'b1;
    @(negedge CLK_IN);
    RD_EN_OUT = 1'b0;
    ADDR_OUT = ~ADDR_OUT;
    d = RDATA_IN;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic        clk, rst, wr, rd, push, pop, ovr, ovf;
  logic        rdbl, act, pcy, prun, pclr, praw, sraw, kraw, ia, ib;
  logic [7:0]  addr, wdata, rdata, pmin, v;
  logic [6:0]  mev, dev, psmp, pprec;
  logic [1:0]  rng, pcode;
  logic [2:0]  band;
  logic [3:0]  slp;
  logic [16:0] pcyc;
  logic [10:0] pquit;
  logic [7:0]  m [256];
  int          lvl, miscompares, tests_run;
  int          us [4] = '{12, 96, 768, 2048};
  mscr_host i_host (.CLK_IN(clk), .RDATA_IN(rdata), .WR_EN_OUT(wr), .RD_EN_OUT(rd),
    .ADDR_OUT(addr), .WDATA_OUT(wdata));
  mscr_regs i_dut (.CLK_IN(clk), .RST_IN(rst), .WR_EN_IN(wr), .RD_EN_IN(rd), .ADDR_IN(addr),
    .WDATA_IN(wdata), .FRAME_PUSH_IN(push), .FRAME_POP_IN(pop), .OVERRUN_IN(ovr),
    .MOTION_EVT_IN(mev), .DATA_EVT_IN(dev), .RDATA_OUT(rdata), .RANGE_SEL_OUT(rng),
    .BAND_SEL_OUT(band), .RATE_DOUBLE_OUT(rdbl), .ACTIVE_MODE_OUT(act),
    .PRESET_CODE_OUT(pcode), .PRESET_CYCLES_OUT(pcyc), .SLEEP_CODE_OUT(slp),
    .POWER_CYCLE_OUT(pcy), .PED_RUN_OUT(prun), .PED_SAMPLES_OUT(psmp),
    .PED_PRECISION_OUT(pprec), .PED_CLEAR_OUT(pclr), .PED_MIN_WIN_OUT(pmin),
    .PED_QUIT_WIN_OUT(pquit), .PED_RAW_OUT(praw), .SAMPLE_RAW_OUT(sraw),
    .KNOCK_RAW_OUT(kraw), .IRQ_PIN_A_OUT(ia), .IRQ_PIN_B_OUT(ib));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h0f: return mscr_pkg::MASK_RANGE;
      8'h10: return mscr_pkg::MASK_BAND;
      8'h12: return mscr_pkg::MASK_PED0;
      8'h13: return 8'h7f;
      8'h16: return mscr_pkg::MASK_EN_MOTION;
      8'h17: return mscr_pkg::MASK_DATA_GRP;
      8'h18: return mscr_pkg::MASK_SRC;
      8'h19, 8'h1b: return mscr_pkg::MASK_MAP_MOT;
      8'h1a, 8'h1c: return mscr_pkg::MASK_MAPA_DATA;
      default: return (a >= 8'h11 && a <= 8'h15) ? 8'hff : 8'h00;
    endcase
  endfunction
  function automatic logic pin(input logic [7:0] mm, input logic [7:0] dm);
    return |(mev & m[8'h16][7:1] & mm[7:1]) | |(dev & m[8'h17][6:0] & {dm[6:3], {3{dm[2]}}});
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    m[a] = ((a == 8'h11) ? (d | 8'h40) : d) & msk(a);
    if (a == 8'h31 || a == 8'h3e) lvl = 0;
  endtask
  task automatic chk_rd(input logic [7:0] a);
    logic [7:0] e;
    logic [7:0] d;
    e = (a == 8'h0e) ? {ovf, lvl[6:0]} : (a >= 8'h0f && a <= 8'h1c) ? m[a] : 8'h00;
    if (a == 8'h0e) ovf = 1'b0;
    i_host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic frames(input logic p, input logic q, input int n);
    repeat (n) begin
      @(negedge clk);
      {push, pop} = {p, q};
      if (p && !q && lvl < 127) lvl++;
      if (q && !p && lvl > 0) lvl--;
    end
    @(negedge clk);
    {push, pop} = 2'b00;
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(38879));
    {push, pop, ovr, ovf, mev, dev} = '0;
    rst = 1'b1;
    foreach (m[j]) m[j] = 8'h00;
    m[8'h12] = 8'h0c;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int a = 14; a <= 32; a++) chk_rd(8'(a));
    chk(16'(psmp), 16'd48);
    chk(pcyc, 16'd480);
    for (int a = 15; a <= 28; a++) begin
      wreg(8'(a), 8'($urandom));
      chk_rd(8'(a));
    end
    for (int i = 0; i < 16; i++) begin
      wreg(8'h0f, 8'(i));
      chk(16'(rng), 16'((i == 2) ? 1 : (i == 4) ? 2 : 0));
    end
    for (int i = 0; i < 64; i++) begin
      wreg(8'h10, 8'(i) | (8'($urandom) & 8'hc0));
      chk(16'({rdbl, band}), 16'({i[5], i[2:0]}));
    end
    for (int i = 0; i < 256; i++) begin
      wreg(8'h11, 8'(i));
      chk(16'({act, pcode, slp, pcy}), 16'({i[7], i[5:4], i[3:0], i[3:0] != 4'h0}));
      chk(pcyc, 17'(us[i[5:4]] * (mscr_pkg::CLK_HZ / 1000000)));
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wreg(8'h12, v);
      chk(16'({prun, psmp}), 16'({v[7], v[4:0], 2'b00}));
      wreg(8'h13, v);
      chk(16'({pclr, pprec}), 16'(v));
      @(negedge clk);
      chk(16'(pclr), 16'h0000);
      wreg(8'h14, v);
      wreg(8'h15, v);
      wreg(8'h18, v);
      chk(16'(pquit), 16'({v, 3'b000}));
      chk(16'({pmin, praw, sraw, kraw}), 16'({v, v[6:4]}));
    end
    // saturate, mix push and pop, then drain past empty
    frames(1'b1, 1'b0, 130);
    chk_rd(8'h0e);
    frames(1'b0, 1'b1, 5);
    frames(1'b1, 1'b1, 3);
    chk_rd(8'h0e);
    frames(1'b0, 1'b1, 130);
    chk_rd(8'h0e);
    frames(1'b1, 1'b0, 9);
    wreg(8'h31, 8'($urandom));
    chk_rd(8'h0e);
    frames(1'b1, 1'b0, 4);
    wreg(8'h3e, 8'($urandom));
    chk_rd(8'h0e);
    @(negedge clk) ovr = 1'b1;
    @(negedge clk) ovr = 1'b0;
    ovf = 1'b1;
    chk_rd(8'h0e);
    chk_rd(8'h0e);
    for (int i = 0; i < 48; i++) begin
      for (int a = 22; a <= 28; a++) if (a != 24) wreg(8'(a), 8'($urandom));
      @(negedge clk);
      mev = 7'($urandom);
      dev = 7'($urandom);
      @(negedge clk);
      chk(16'({ia, ib}), 16'({pin(m[8'h19], m[8'h1a]), pin(m[8'h1b], m[8'h1c])}));
    end
    conclude();
  end
endmodule
